// ===== pulse_cfg_pkg.sv
// What this block does
// - First output source select bits [2:0], reset 000
// - Reserved first-output codes suppress first pulses
// - Second output source select bits [5:3], reset 001
// - Reserved second-output codes suppress second pulses
// - Third output source select bits [8:6], reset 010
// - Reserved third-output codes suppress third pulses
// - Bit 9 disables first pin; converter keeps running
// - Bit 10 disables second pin; converter keeps running
// - Bit 11 disables third pin; converter keeps running
// - Bit 12 latches first-output energy on pulse
// - Bit 13 latches second-output energy on pulse
// - Bit 14 latches third-output energy on pulse
// - Phase-include bits choose phases summed per output
package pulse_cfg_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PWR_W = 24;
    localparam int ACC_W = 32;
    localparam logic [ADDR_W-1:0] PULSE_OUTPUT_CONFIG_IDX = 16'he610;
    localparam logic [ADDR_W-1:0] PHASE_INCLUDE_IDX = 16'he700;
    localparam logic [ADDR_W-1:0] PULSE_STATUS_IDX = 16'he701;
    localparam logic [ADDR_W-1:0] LATCHED_ENERGY0_IDX = 16'he702;
    localparam int SRC0_LSB = 0;
    localparam int SRC1_LSB = 3;
    localparam int SRC2_LSB = 6;
    localparam int DIS_LSB = 9;
    localparam int LATCH_LSB = 12;
    localparam logic [15:0] PULSE_OUTPUT_CONFIG_RST = 16'h0e88;
    localparam logic [8:0] PHASE_INCLUDE_RST = 9'h1ff;
    localparam logic [2:0] SRC_MAX_LEGAL = 3'h4;
    localparam logic [ACC_W-1:0] PULSE_THRESHOLD_RST = 32'h0100_0000;
    localparam int PULSE_WIDTH_NS = 80000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_WIDTH_CYC = PULSE_WIDTH_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        SRC_TOTAL_ACTIVE = 3'h0,
        SRC_TOTAL_REACTIVE = 3'h1,
        SRC_APPARENT = 3'h2,
        SRC_FUND_ACTIVE = 3'h3,
        SRC_FUND_REACTIVE = 3'h4
    } source_sel_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ANSWER = 2'h1
    } bus_state_t;
endpackage : pulse_cfg_pkg

// ===== pulse_output_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_output_mode_control #(
    parameter int PULSE_WIDTH = pulse_cfg_pkg::PULSE_WIDTH_CYC
) (
    input wire logic clk_in, // Core clock
    input wire logic rst_n_in, // Sync reset, low
    input wire logic [pulse_cfg_pkg::ADDR_W-1:0] avs_address_in, // Word index
    input wire logic avs_read_in, // Read request
    input wire logic avs_write_in, // Write request
    input wire logic [pulse_cfg_pkg::DATA_W-1:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Byte lanes
    output logic [pulse_cfg_pkg::DATA_W-1:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall
    input wire logic [5*3*pulse_cfg_pkg::PWR_W-1:0] phase_power_in, // Quantity q, phase p
    input wire logic power_strobe_in, // New power sample
    output logic [2:0] pulse_output_out, // Pulse pins, high = active
    output logic [2:0] energy_latch_out // Latch strobes
);
    import pulse_cfg_pkg::*;

    typedef struct packed {
        bus_state_t bus;
        logic stall;
        logic [DATA_W-1:0] rdata;
        logic [15:0] cfg;
        logic [8:0] incl;
        logic [2:0][ACC_W-1:0] acc;
        logic [2:0][15:0] width_cnt;
        logic [2:0] pin;
        logic [2:0] latch;
        logic [2:0] seen;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic [PWR_W-1:0] pick(input logic [2:0] q, input logic [1:0] p);
        pick = phase_power_in[(int'(q) * 3 + int'(p)) * PWR_W +: PWR_W];
    endfunction : pick

    function automatic logic [ACC_W-1:0] sum_sel(input logic [2:0] q, input logic [2:0] inc);
        logic [ACC_W-1:0] t;
        t = '0;
        for (int p = 0; p < 3; p++) begin
            if (inc[p]) begin
                t = t + ACC_W'(pick(q, 2'(p)));
            end
        end
        sum_sel = t;
    endfunction : sum_sel

    logic [2:0][2:0] src;
    logic [2:0] fire;

    always_comb begin
        logic [ACC_W-1:0] add;
        logic [DATA_W-1:0] wmask;
        add = '0;
        wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                 {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        s_next = s_reg;
        s_next.latch = '0;
        src[0] = s_reg.cfg[SRC0_LSB +: 3];
        src[1] = s_reg.cfg[SRC1_LSB +: 3];
        src[2] = s_reg.cfg[SRC2_LSB +: 3];
        fire = '0;
        for (int i = 0; i < 3; i++) begin
            // Converter accumulates unless the source code is reserved; pin gating is separate
            if (power_strobe_in && src[i] <= SRC_MAX_LEGAL) begin
                add = sum_sel(src[i], s_reg.incl[i*3 +: 3]);
                if (s_reg.acc[i] + add >= PULSE_THRESHOLD_RST) begin
                    fire[i] = 1'b1;
                    s_next.acc[i] = s_reg.acc[i] + add - PULSE_THRESHOLD_RST;
                end else begin
                    s_next.acc[i] = s_reg.acc[i] + add;
                end
            end
            if (fire[i]) begin
                s_next.seen[i] = 1'b1;
                s_next.latch[i] = s_reg.cfg[LATCH_LSB + i];
                if (!s_reg.cfg[DIS_LSB + i]) begin
                    s_next.pin[i] = 1'b1;
                    s_next.width_cnt[i] = 16'(PULSE_WIDTH);
                end
            end else if (s_reg.width_cnt[i] > 16'h0001) begin
                s_next.width_cnt[i] = s_reg.width_cnt[i] - 16'h0001;
            end else begin
                s_next.width_cnt[i] = '0;
                s_next.pin[i] = 1'b0;
            end
            if (s_reg.cfg[DIS_LSB + i] || src[i] > SRC_MAX_LEGAL) begin
                s_next.pin[i] = 1'b0;
                s_next.width_cnt[i] = '0;
            end
        end
        unique case (s_reg.bus)
            BUS_IDLE: begin
                if (avs_write_in) begin
                    s_next.bus = BUS_ANSWER;
                end else if (avs_read_in) begin
                    s_next.bus = BUS_ANSWER;
                    if (avs_address_in == PULSE_OUTPUT_CONFIG_IDX) begin
                        s_next.rdata = {16'h0000, s_reg.cfg};
                    end else if (avs_address_in == PHASE_INCLUDE_IDX) begin
                        s_next.rdata = {23'h000000, s_reg.incl};
                    end else if (avs_address_in == PULSE_STATUS_IDX) begin
                        s_next.rdata = {26'h0000000, s_reg.pin, s_reg.seen};
                    end else begin
                        s_next.rdata = '0;
                    end
                end
            end
            BUS_ANSWER: begin
                s_next.bus = BUS_IDLE;
                // Write lands on the edge that completes the transfer
                if (avs_write_in) begin
                    if (avs_address_in == PULSE_OUTPUT_CONFIG_IDX) begin
                        s_next.cfg = (s_reg.cfg & ~wmask[15:0]) |
                                     (avs_writedata_in[15:0] & wmask[15:0]);
                    end else if (avs_address_in == PHASE_INCLUDE_IDX) begin
                        s_next.incl = (s_reg.incl & ~wmask[8:0]) |
                                      (avs_writedata_in[8:0] & wmask[8:0]);
                    end else if (avs_address_in == PULSE_STATUS_IDX) begin
                        // Write one to clear; a new pulse wins
                        s_next.seen = (s_reg.seen & ~(avs_writedata_in[2:0] & wmask[2:0]))
                                      | fire;
                    end
                end
            end
            default: begin
                s_next.bus = BUS_IDLE;
            end
        endcase
        s_next.stall = (s_next.bus == BUS_IDLE);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_reg.bus <= BUS_IDLE;
            s_reg.stall <= 1'b1;
            s_reg.rdata <= '0;
            s_reg.cfg <= PULSE_OUTPUT_CONFIG_RST;
            s_reg.incl <= PHASE_INCLUDE_RST;
            s_reg.acc <= '0;
            s_reg.width_cnt <= '0;
            s_reg.pin <= '0;
            s_reg.latch <= '0;
            s_reg.seen <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata_out = s_reg.rdata;
    assign avs_waitrequest_out = s_reg.stall;
    assign pulse_output_out = s_reg.pin;
    assign energy_latch_out = s_reg.latch;

    property p_reset_cfg;
        @(posedge clk_in) $rose(rst_n_in) |-> s_reg.cfg == 16'h0e88;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("cfg reset wrong");

    property p_src_reserved;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[2:0] > 3'h4) |=> !pulse_output_out[0];
    endproperty
    a_src_reserved: assert property (p_src_reserved) else $error("reserved code pulsed");

    property p_src2_reserved;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[5:3] > 3'h4) |-> !fire[1] ##1 !pulse_output_out[1];
    endproperty
    a_src2_reserved: assert property (p_src2_reserved) else $error("second reserved pin");

    property p_src3_reserved;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[8:6] > 3'h4) |-> !fire[2];
    endproperty
    a_src3_reserved: assert property (p_src3_reserved) else $error("third reserved fired");

    property p_dis_pin;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[9] |=> !pulse_output_out[0];
    endproperty
    a_dis_pin: assert property (p_dis_pin) else $error("disabled pin active");

    property p_dis2_pin;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[10] |=> !pulse_output_out[1];
    endproperty
    a_dis2_pin: assert property (p_dis2_pin) else $error("second disabled pin active");

    property p_dis3_fire;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[11] && fire[2] |=> !pulse_output_out[2] && s_reg.seen[2];
    endproperty
    a_dis3_fire: assert property (p_dis3_fire) else $error("third converter stalled");

    property p_latch;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[0] |=> energy_latch_out[0] == $past(s_reg.cfg[12]);
    endproperty
    a_latch: assert property (p_latch) else $error("first latch mismatch");

    property p_latch_only_fire;
        @(posedge clk_in) disable iff (!rst_n_in)
            !fire[1] |=> !energy_latch_out[1];
    endproperty
    a_latch_only_fire: assert property (p_latch_only_fire) else $error("stray latch");

    property p_pulse_start;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[2] && !s_reg.cfg[11] && s_reg.cfg[8:6] <= 3'h4 |=> pulse_output_out[2];
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("enabled pin missed pulse");

    property p_rst_out;
        @(posedge clk_in) $rose(rst_n_in) |->
            pulse_output_out == 3'h0 && energy_latch_out == 3'h0 && avs_waitrequest_out;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset outputs");

    property p_rst_incl;
        @(posedge clk_in) $rose(rst_n_in) |-> s_reg.incl == PHASE_INCLUDE_RST;
    endproperty
    a_rst_incl: assert property (p_rst_incl) else $error("include reset");

    property p_wait_one;
        @(posedge clk_in) disable iff (!rst_n_in)
            (avs_read_in || avs_write_in) && s_reg.bus == BUS_IDLE |=> !avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer");

    property p_wait_single;
        @(posedge clk_in) disable iff (!rst_n_in)
            !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("long answer");

    property p_cfg_write;
        @(posedge clk_in) disable iff (!rst_n_in)
            avs_write_in && !avs_waitrequest_out && avs_address_in == PULSE_OUTPUT_CONFIG_IDX
            && avs_byteenable_in == 4'hf |=> s_reg.cfg == 16'($past(avs_writedata_in));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write");

    property p_cfg_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
            !(avs_write_in && !avs_waitrequest_out) |=> $stable(s_reg.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");

    property p_src1_res;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[2:0] > 3'h4) |-> !fire[0];
    endproperty
    a_src1_res: assert property (p_src1_res) else $error("first reserved fired");

    property p_src2_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[5:3] > 3'h4) |=> $stable(s_reg.acc[1]);
    endproperty
    a_src2_hold: assert property (p_src2_hold) else $error("second acc moved");

    property p_src3_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
            (s_reg.cfg[8:6] > 3'h4) |=> $stable(s_reg.acc[2]);
    endproperty
    a_src3_hold: assert property (p_src3_hold) else $error("third acc moved");

    property p_dis1_fire;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[9] && fire[0] |=> !pulse_output_out[0] && s_reg.seen[0];
    endproperty
    a_dis1_fire: assert property (p_dis1_fire) else $error("first stalled");

    property p_dis2_fire;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[10] && fire[1] |=> !pulse_output_out[1] && s_reg.seen[1];
    endproperty
    a_dis2_fire: assert property (p_dis2_fire) else $error("second stalled");

    property p_dis3_pin;
        @(posedge clk_in) disable iff (!rst_n_in)
            s_reg.cfg[11] |=> !pulse_output_out[2];
    endproperty
    a_dis3_pin: assert property (p_dis3_pin) else $error("third pin active");

    property p_latch2;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[1] && s_reg.cfg[13] |=> energy_latch_out[1];
    endproperty
    a_latch2: assert property (p_latch2) else $error("second latch missing");

    property p_latch3;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[2] && s_reg.cfg[14] |=> energy_latch_out[2];
    endproperty
    a_latch3: assert property (p_latch3) else $error("third latch missing");

    property p_latch3_only;
        @(posedge clk_in) disable iff (!rst_n_in)
            (!fire[2] || !s_reg.cfg[14]) |=> !energy_latch_out[2];
    endproperty
    a_latch3_only: assert property (p_latch3_only) else $error("stray third latch");

    property p_latch1_only;
        @(posedge clk_in) disable iff (!rst_n_in)
            !fire[0] |=> !energy_latch_out[0];
    endproperty
    a_latch1_only: assert property (p_latch1_only) else $error("stray first latch");

    property p_no_strobe;
        @(posedge clk_in) disable iff (!rst_n_in)
            !power_strobe_in |-> fire == 3'h0;
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("fire without sample");

    property p_start1;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[0] && !s_reg.cfg[9] |=> pulse_output_out[0];
    endproperty
    a_start1: assert property (p_start1) else $error("first pulse missed");

    property p_start2;
        @(posedge clk_in) disable iff (!rst_n_in)
            fire[1] && !s_reg.cfg[10] |=> pulse_output_out[1];
    endproperty
    a_start2: assert property (p_start2) else $error("second pulse missed");

    property p_no_spurious;
        @(posedge clk_in) disable iff (!rst_n_in)
            !fire[0] && !pulse_output_out[0] |=> !pulse_output_out[0];
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious pulse");

    property p_width;
        @(posedge clk_in) disable iff (!rst_n_in)
            $rose(pulse_output_out[0]) |-> s_reg.width_cnt[0] == 16'(PULSE_WIDTH);
    endproperty
    a_width: assert property (p_width) else $error("pulse width load");

    c_pulse0: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(pulse_output_out[0]));
    c_latch2: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        energy_latch_out[2]);
    c_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        avs_write_in && !avs_waitrequest_out);
    c_reserved2: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        power_strobe_in && s_reg.cfg[5:3] > 3'h4);
    c_fire_disabled: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        fire[0] && s_reg.cfg[9]);
endmodule : pulse_output_mode_control
`default_nettype wire

// ===== pulse_led_model.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_led_model (
    input wire logic clk_in, // Core clock
    input wire logic rst_n_in, // Sync reset, low
    input wire logic [2:0] pins_in, // Pulse pins, high lights
    output logic [23:0] flash_count_out // Flashes, 8 bits per pin
);
    logic [2:0] last_reg;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            last_reg <= 3'h0;
            flash_count_out <= 24'h0;
        end else begin
            last_reg <= pins_in;
            for (int i = 0; i < 3; i++) begin
                if (pins_in[i] && !last_reg[i]) begin
                    flash_count_out[8*i +: 8] <= flash_count_out[8*i +: 8] + 8'h1;
                end
            end
        end
    end
endmodule : pulse_led_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pulse_cfg_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic wait_req;
    logic [5*3*PWR_W-1:0] power = '0;
    logic strobe = 1'b0;
    logic [2:0] pins;
    logic [2:0] latches;
    logic [23:0] flashes;
    logic [15:0] cfg_now;
    logic [8:0] incl_now;
    logic [2:0] crossed;
    int num_errors = 0;
    int check_count = 0;
    int exp_flash [3] = '{0, 0, 0};
    int exp_latch [3] = '{0, 0, 0};
    int latch_seen [3] = '{0, 0, 0};
    longint acc [3] = '{0, 0, 0};
    pulse_output_mode_control #(.PULSE_WIDTH(4)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
        .phase_power_in(power), .power_strobe_in(strobe), .pulse_output_out(pins),
        .energy_latch_out(latches));
    pulse_led_model i_led (.clk_in(clk_in), .rst_n_in(rst_n_in), .pins_in(pins),
        .flash_count_out(flashes));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) for (int i = 0; i < 3; i++) if (latches[i] === 1'b1) latch_seen[i]++;
    function automatic logic [23:0] pw(input int q, input int p);
        return 24'h2a0001 + 24'(q) * 24'h0c1100 + 24'(p) * 24'h031000;
    endfunction : pw
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        rd <= !we;
        wr <= we;
        addr <= a;
        wdata <= d;
        // Sampled at the rising edge, before that edge's updates land
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0) begin
            num_errors++;
            conclude();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask : bus
    task automatic step;
        logic [2:0] c;
        strobe <= 1'b1;
        @(posedge clk_in);
        strobe <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            c = cfg_now[3*i +: 3];
            if (c <= SRC_MAX_LEGAL) begin
                for (int p = 0; p < 3; p++) if (incl_now[3*i+p]) acc[i] += pw(c, p);
                if (acc[i] >= PULSE_THRESHOLD_RST) begin
                    acc[i] -= PULSE_THRESHOLD_RST;
                    crossed[i] = 1'b1;
                    exp_flash[i] += !cfg_now[DIS_LSB+i];
                    exp_latch[i] += cfg_now[LATCH_LSB+i];
                end
            end
        end
        repeat (12) @(posedge clk_in);
    endtask : step
    task automatic run_case(input logic [15:0] cfg, input logic [8:0] incl, input int n);
        logic [31:0] q;
        bus(1'b1, PULSE_OUTPUT_CONFIG_IDX, {16'h0, cfg}, q);
        bus(1'b1, PHASE_INCLUDE_IDX, {23'h0, incl}, q);
        bus(1'b1, PULSE_STATUS_IDX, 32'h7, q);
        cfg_now = cfg;
        incl_now = incl;
        crossed = 3'h0;
        bus(1'b0, PULSE_OUTPUT_CONFIG_IDX, 32'h0, q);
        check("config", {16'h0, cfg}, q);
        repeat (n) step();
        bus(1'b0, PULSE_STATUS_IDX, 32'h0, q);
        check("status", {29'h0, crossed}, q);
        for (int i = 0; i < 3; i++) begin
            check("flashes", 32'(exp_flash[i] % 256), {24'h0, flashes[8*i +: 8]});
            check("latches", 32'(exp_latch[i]), 32'(latch_seen[i]));
        end
    endtask : run_case
    task automatic t_reset;
        logic [31:0] q;
        bus(1'b0, PULSE_OUTPUT_CONFIG_IDX, 32'h0, q);
        check("config reset", 32'h0e88, q);
        bus(1'b0, PHASE_INCLUDE_IDX, 32'h0, q);
        check("include reset", 32'h1ff, q);
        bus(1'b1, 16'h0001, 32'hffff, q);
        bus(1'b0, PULSE_OUTPUT_CONFIG_IDX, 32'h0, q);
        check("config kept", 32'h0e88, q);
        bus(1'b0, 16'h0001, 32'h0, q);
        check("unmapped", 32'h0, q);
    endtask : t_reset
    task automatic t_sources;
        for (int c = 0; c < 5; c++) run_case({4'h7, 3'h0, 3'((c+2)%5), 3'((c+1)%5), 3'(c)}, 9'h1ff, 5);
    endtask : t_sources
    task automatic t_reserved;
        for (int c = 5; c < 8; c++) begin
            run_case({4'h7, 3'h0, 3'(c), 3'(c-5), 3'(c)}, 9'h1ff, 4);
            run_case({4'h7, 3'h0, 3'(c-5), 3'(c), 3'(c-5)}, 9'h1ff, 4);
        end
    endtask : t_reserved
    task automatic t_disable;
        run_case(16'h5e88, 9'h1ff, 5);
        run_case(16'h0488, 9'h1ff, 4);
    endtask : t_disable
    task automatic t_include;
        run_case(16'h7088, 9'h111, 6);
        run_case(16'h7088, 9'h0a6, 5);
    endtask : t_include
    initial begin
        for (int q = 0; q < 5; q++) for (int p = 0; p < 3; p++) power[(q*3+p)*PWR_W +: PWR_W] = pw(q, p);
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_sources();
        t_reserved();
        t_disable();
        t_include();
        conclude();
    end
endmodule : tb
`default_nettype wire
